// ### inc/hafd_pkg.sv
// Constants shared by the API frame decoder files.
// Assumes a byte stream already de-serialised and synchronous to pclk.
package hafd_pkg;
  localparam logic [7:0]  START_DELIM    = 8'h7E;
  localparam logic [7:0]  ESC_BYTE       = 8'h7D;
  localparam logic [7:0]  ESC_XOR        = 8'h20;
  localparam logic [7:0]  XON_BYTE       = 8'h11;
  localparam logic [7:0]  XOFF_BYTE      = 8'h13;
  localparam logic [7:0]  CSUM_GOOD      = 8'hFF;
  localparam logic [7:0]  TYPE_TX16      = 8'h01;
  localparam logic [7:0]  TYPE_LOCAL_CMD = 8'h08;
  localparam logic [7:0]  TYPE_LOCAL_RSP = 8'h88;
  localparam logic [7:0]  TYPE_TX_STATUS = 8'h89;
  localparam logic [15:0] ADDR_BCAST     = 16'hFFFF;
  localparam int          OPT_NO_ACK     = 0;
  localparam int          OPT_BCAST_PAN  = 2;
  // Body offsets counted from the frame type byte (frame offset 3).
  localparam logic [15:0] BOFS_ID        = 16'h0001;
  localparam logic [15:0] BOFS_HI        = 16'h0002;
  localparam logic [15:0] BOFS_LO        = 16'h0003;
  localparam logic [15:0] BOFS_OPT       = 16'h0004;
  localparam logic [15:0] BOFS_PAYLOAD   = 16'h0005;
  localparam logic [15:0] BOFS_PARAM     = 16'h0004;
  localparam logic [15:0] LEN_QUERY      = 16'h0004;
  localparam logic [15:0] LEN_TX_MIN     = 16'h0005;
  // Status codes for responses.
  localparam logic [7:0]  STAT_OK        = 8'h00;
  localparam logic [7:0]  STAT_ERROR     = 8'h01;
  // APB register map (byte addresses).
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_MAXPAY     = 8'h08;
  localparam logic [7:0]  REG_COUNT      = 8'h0C;
  localparam int          CTRL_ESC_EN    = 0;
  localparam logic [15:0] MAXPAY_RESET   = 16'h0064;
  localparam logic [15:0] CMD_MAXPAY     = 16'h4E50;
  typedef enum logic [2:0] {
    HAFD_HUNT  = 3'b000,
    HAFD_LEN_H = 3'b001,
    HAFD_LEN_L = 3'b011,
    HAFD_BODY  = 3'b010,
    HAFD_CSUM  = 3'b110
  } hafd_state_e;
endpackage

// ### rtl/hafd_unescape.sv
// Removes escape sequences from the incoming byte stream.
// Assumes in_valid is a one-cycle strobe per received byte.
`timescale 1ns/1ns
module hafd_unescape
  import hafd_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       esc_en,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  output logic            out_valid,
  output logic            out_start,
  output logic [7:0]      out_byte
);
  logic pend_reg;

  // A raw delimiter always restarts framing, even after a stray escape.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg  <= 1'b0;
      out_valid <= 1'b0;
      out_start <= 1'b0;
      out_byte  <= 8'h00;
    end else if (ce) begin
      out_valid <= 1'b0;
      out_start <= 1'b0;
      if (in_valid) begin
        if (in_byte == START_DELIM) begin
          pend_reg  <= 1'b0;
          out_start <= 1'b1;
          out_valid <= 1'b1;
          out_byte  <= in_byte;
        end else if (esc_en && in_byte == ESC_BYTE && !pend_reg) begin
          pend_reg <= 1'b1;
        end else begin
          pend_reg  <= 1'b0;
          out_valid <= 1'b1;
          out_byte  <= pend_reg ? (in_byte ^ ESC_XOR) : in_byte;
        end
      end
    end
  end

  property p_esc_xor;
    @(posedge pclk) disable iff (!presetn)
    ce && in_valid && esc_en && pend_reg && in_byte != START_DELIM |=>
    out_valid && out_byte == ($past(in_byte) ^ ESC_XOR);
  endproperty
  a_esc_xor: assert property (p_esc_xor) else $error("escape not undone");
endmodule // hafd_unescape

// ### rtl/hafd_apb_regs.sv
// APB slave holding control, status and parameter registers.
// Assumes a standard APB master; answers with zero wait states.
`timescale 1ns/1ns
module hafd_apb_regs
  import hafd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  stat_in,
  input  wire logic [15:0] frame_cnt,
  input  wire logic        maxpay_we,
  input  wire logic [15:0] maxpay_wd,
  output logic             esc_en,
  output logic [15:0]      maxpay
);
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_mux;
  assign acc    = psel && penable;
  assign wr     = acc && pready && pwrite;
  assign mapped = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_MAXPAY ||
                  paddr == REG_COUNT;

  // A frame write and a bus write in the same cycle: the frame wins, being later news.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esc_en <= 1'b0;
      maxpay <= MAXPAY_RESET;
    end else if (ce) begin
      if (wr && paddr == REG_CTRL) esc_en <= pwdata[CTRL_ESC_EN];
      if (maxpay_we) maxpay <= maxpay_wd;
      else if (wr && paddr == REG_MAXPAY) maxpay <= pwdata[15:0];
    end
  end

  // Answer and read data are registered in the setup cycle, so the access cycle
  // that follows still completes at once while every bus output leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL:   rd_mux = {31'h0000_0000, esc_en};
      REG_STATUS: rd_mux = {24'h00_0000, stat_in};
      REG_MAXPAY: rd_mux = {16'h0000, maxpay};
      REG_COUNT:  rd_mux = {16'h0000, frame_cnt};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end
endmodule // hafd_apb_regs

// ### rtl/hafd_frame_decoder.sv
// Host API frame decoder: parses transmit and local command frames.
// Assumes bytes arrive as one-cycle strobes synchronous to pclk.
// What this block does
// - Type 01 is transmit, answered with 89
// - Length at offset 1 counts body bytes
// - Frame ID echoed; zero suppresses responses
// - Destination at 5..6; FFFF means broadcast
// - Option bit0 no-ack, bit2 broadcast PAN
// - Payload from offset 8; max size queryable
// - Checksum is FF minus body sum
// - Type 08 is local command, answered 88
// - Offset 5..6 names the command
// - Parameter bytes set and apply at once
// - No parameter bytes means a query
// - Command response carries request frame ID
// - Transmit status reports transmission success
// - Command response always reports status OK
// - Frames start 7E; header excluded from sum
// - Escaped mode undoes 7D-prefixed bytes
// - Length and checksum use unescaped values
// - Bad checksum frames get no request or response; payload still streams
`timescale 1ns/1ns
module hafd_frame_decoder
  import hafd_pkg::*;
#(
  parameter int MAX_BODY = 256
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        tx_done,
  input  wire logic        tx_ok,
  output logic             tx_req,
  output logic [15:0]      tx_dest,
  output logic             tx_bcast,
  output logic             tx_no_ack,
  output logic             tx_bcast_pan,
  output logic [15:0]      tx_len,
  output logic             pay_valid,
  output logic [7:0]       pay_byte,
  output logic             param_we,
  output logic [15:0]      param_cmd,
  output logic [7:0]       param_byte,
  output logic             rsp_valid,
  output logic [7:0]       rsp_type,
  output logic [7:0]       rsp_id,
  output logic [7:0]       rsp_status,
  output logic [15:0]      rsp_value
);
  logic        bv;
  logic        bstart;
  logic [7:0]  bb;
  logic        esc_en;
  logic [15:0] maxpay;
  hafd_state_e state_reg;
  logic [15:0] len_reg;
  logic [15:0] idx_reg;
  logic [7:0]  sum_reg;
  logic [7:0]  type_reg;
  logic [7:0]  id_reg;
  logic [7:0]  opt_reg;
  logic [15:0] addr_reg;
  logic [15:0] pval_reg;
  logic        tx_pend_reg;
  logic [7:0]  tx_id_reg;
  logic [15:0] cnt_reg;
  logic [7:0]  last_stat_reg;
  logic        good;
  logic        csum_ok;
  logic        known;
  logic        is_cmd;
  logic        mp_we;

  hafd_unescape u_unesc (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .esc_en    (esc_en),
    .in_valid  (rx_valid),
    .in_byte   (rx_byte),
    .out_valid (bv),
    .out_start (bstart),
    .out_byte  (bb)
  );

  hafd_apb_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pready    (pready),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .stat_in   (last_stat_reg),
    .frame_cnt (cnt_reg),
    .maxpay_we (mp_we),
    .maxpay_wd (pval_reg),
    .esc_en    (esc_en),
    .maxpay    (maxpay)
  );

  assign csum_ok = (sum_reg + bb) == CSUM_GOOD;
  assign known   = type_reg == TYPE_TX16 || type_reg == TYPE_LOCAL_CMD;
  assign is_cmd  = type_reg == TYPE_LOCAL_CMD;
  assign good    = bv && state_reg == HAFD_CSUM && csum_ok && known;
  // The max-payload entry is mirrored in a register so software sees it too.
  assign mp_we   = good && is_cmd && len_reg > LEN_QUERY && addr_reg == CMD_MAXPAY;

  // Frame state machine; a delimiter anywhere restarts it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= HAFD_HUNT;
      len_reg   <= 16'h0000;
      idx_reg   <= 16'h0000;
      sum_reg   <= 8'h00;
    end else if (ce && bv) begin
      if (bstart) begin
        state_reg <= HAFD_LEN_H;
      end else begin
        unique case (state_reg)
          HAFD_HUNT: state_reg <= HAFD_HUNT;
          HAFD_LEN_H: begin
            len_reg[15:8] <= bb;
            state_reg     <= HAFD_LEN_L;
          end
          HAFD_LEN_L: begin
            len_reg[7:0] <= bb;
            idx_reg      <= 16'h0000;
            sum_reg      <= 8'h00;
            state_reg    <= ({len_reg[15:8], bb} == 16'h0000 ||
                             {len_reg[15:8], bb} > MAX_BODY[15:0]) ? HAFD_HUNT : HAFD_BODY;
          end
          HAFD_BODY: begin
            sum_reg <= sum_reg + bb;
            idx_reg <= idx_reg + 16'h0001;
            if (idx_reg + 16'h0001 == len_reg) state_reg <= HAFD_CSUM;
          end
          HAFD_CSUM: state_reg <= HAFD_HUNT;
          default:   state_reg <= HAFD_HUNT;
        endcase
      end
    end
  end

  // Field capture by body offset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      type_reg <= 8'h00;
      id_reg   <= 8'h00;
      opt_reg  <= 8'h00;
      addr_reg <= 16'h0000;
      pval_reg <= 16'h0000;
    end else if (ce && bv && !bstart && state_reg == HAFD_BODY) begin
      if (idx_reg == 16'h0000) type_reg <= bb;
      if (idx_reg == BOFS_ID) id_reg <= bb;
      if (idx_reg == BOFS_HI) addr_reg[15:8] <= bb;
      if (idx_reg == BOFS_LO) addr_reg[7:0] <= bb;
      if (idx_reg == BOFS_OPT) opt_reg <= bb;
      // The first value byte clears the upper byte, so a short value never
      // inherits bytes of an earlier frame.
      if (idx_reg == BOFS_PARAM) pval_reg <= {8'h00, bb};
      else if (idx_reg > BOFS_PARAM) pval_reg <= {pval_reg[7:0], bb};
    end
  end

  // Parameter writes wait for a good checksum, but payload bytes leave as they arrive,
  // so the downstream sinks must treat them as tentative until tx_req or rsp.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pay_valid  <= 1'b0;
      pay_byte   <= 8'h00;
      param_we   <= 1'b0;
      param_cmd  <= 16'h0000;
      param_byte <= 8'h00;
    end else if (ce) begin
      pay_valid <= bv && !bstart && state_reg == HAFD_BODY && type_reg == TYPE_TX16 &&
                   idx_reg >= BOFS_PAYLOAD;
      pay_byte  <= bb;
      param_we  <= good && is_cmd && len_reg > LEN_QUERY;
      param_cmd <= addr_reg;
      param_byte <= pval_reg[7:0];
    end
  end

  // Transmit request towards the radio, issued only for a verified frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_req       <= 1'b0;
      tx_dest      <= 16'h0000;
      tx_bcast     <= 1'b0;
      tx_no_ack    <= 1'b0;
      tx_bcast_pan <= 1'b0;
      tx_len       <= 16'h0000;
      tx_pend_reg  <= 1'b0;
      tx_id_reg    <= 8'h00;
    end else if (ce) begin
      tx_req <= 1'b0;
      if (good && !is_cmd && len_reg >= LEN_TX_MIN) begin
        tx_req       <= 1'b1;
        tx_dest      <= addr_reg;
        tx_bcast     <= addr_reg == ADDR_BCAST;
        tx_no_ack    <= opt_reg[OPT_NO_ACK];
        tx_bcast_pan <= opt_reg[OPT_BCAST_PAN];
        tx_len       <= len_reg - LEN_TX_MIN;
        tx_pend_reg  <= 1'b1;
        tx_id_reg    <= id_reg;
      end else if (tx_done) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  // Responses; a command response takes priority over a finished transmission.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid     <= 1'b0;
      rsp_type      <= 8'h00;
      rsp_id        <= 8'h00;
      rsp_status    <= STAT_OK;
      rsp_value     <= 16'h0000;
      cnt_reg       <= 16'h0000;
      last_stat_reg <= STAT_OK;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      if (good) cnt_reg <= cnt_reg + 16'h0001;
      if (good && is_cmd) begin
        rsp_valid  <= id_reg != 8'h00;
        rsp_type   <= TYPE_LOCAL_RSP;
        rsp_id     <= id_reg;
        rsp_status <= STAT_OK;
        rsp_value  <= (len_reg == LEN_QUERY && addr_reg == CMD_MAXPAY) ? maxpay : 16'h0000;
        last_stat_reg <= STAT_OK;
      end else if (tx_done && tx_pend_reg) begin
        rsp_valid  <= tx_id_reg != 8'h00;
        rsp_type   <= TYPE_TX_STATUS;
        rsp_id     <= tx_id_reg;
        rsp_status <= tx_ok ? STAT_OK : STAT_ERROR;
        rsp_value  <= 16'h0000;
        last_stat_reg <= tx_ok ? STAT_OK : STAT_ERROR;
      end
    end
  end

  property p_bad_csum;
    @(posedge pclk) disable iff (!presetn)
    ce && bv && state_reg == HAFD_CSUM && !csum_ok |=> !tx_req && !rsp_valid && !param_we;
  endproperty
  a_bad_csum: assert property (p_bad_csum) else $error("bad frame acted on");

  property p_zero_id;
    @(posedge pclk) disable iff (!presetn) rsp_valid |-> rsp_id != 8'h00;
  endproperty
  a_zero_id: assert property (p_zero_id) else $error("response for zero id");

  property p_bcast;
    @(posedge pclk) disable iff (!presetn) tx_req |-> tx_bcast == (tx_dest == ADDR_BCAST);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");

  property p_cmd_rsp;
    @(posedge pclk) disable iff (!presetn)
    ce && good && is_cmd && id_reg != 8'h00 |=> rsp_valid && rsp_type == TYPE_LOCAL_RSP &&
    rsp_id == $past(id_reg);
  endproperty
  a_cmd_rsp: assert property (p_cmd_rsp) else $error("command response missing");

  property p_tx_req;
    @(posedge pclk) disable iff (!presetn)
    ce && good && type_reg == TYPE_TX16 && len_reg >= LEN_TX_MIN |=> tx_req &&
    tx_no_ack == $past(opt_reg[OPT_NO_ACK]);
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("transmit not issued");

  property p_tx_stat;
    @(posedge pclk) disable iff (!presetn)
    rsp_valid && rsp_type == TYPE_TX_STATUS |-> rsp_status == ($past(tx_ok) ? STAT_OK : STAT_ERROR);
  endproperty
  a_tx_stat: assert property (p_tx_stat) else $error("status wrong");

  property p_hunt;
    @(posedge pclk) disable iff (!presetn)
    ce && bv && state_reg == HAFD_CSUM && !bstart |=> state_reg == HAFD_HUNT;
  endproperty
  a_hunt: assert property (p_hunt) else $error("no return to hunt");

  property p_start;
    @(posedge pclk) disable iff (!presetn) ce && bv && bstart |=> state_reg == HAFD_LEN_H;
  endproperty
  a_start: assert property (p_start) else $error("delimiter not taken");

  property p_unknown;
    @(posedge pclk) disable iff (!presetn)
    ce && bv && state_reg == HAFD_CSUM && !known |=> !tx_req && !param_we;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown frame acted on");

  property p_param;
    @(posedge pclk) disable iff (!presetn)
    ce && good && is_cmd && len_reg > LEN_QUERY |=> param_we && param_cmd == $past(addr_reg);
  endproperty
  a_param: assert property (p_param) else $error("parameter write missing");

  property p_query;
    @(posedge pclk) disable iff (!presetn)
    ce && good && is_cmd && len_reg == LEN_QUERY && addr_reg == CMD_MAXPAY |=>
    rsp_value == $past(maxpay);
  endproperty
  a_query: assert property (p_query) else $error("query value wrong");

  property p_tx_rsp;
    @(posedge pclk) disable iff (!presetn)
    ce && tx_done && tx_pend_reg && !(good && is_cmd) && tx_id_reg != 8'h00 |=>
    rsp_valid && rsp_type == TYPE_TX_STATUS && rsp_id == $past(tx_id_reg);
  endproperty
  a_tx_rsp: assert property (p_tx_rsp) else $error("transmit status missing");

  property p_tx_fields;
    @(posedge pclk) disable iff (!presetn)
    ce && good && type_reg == TYPE_TX16 && len_reg >= LEN_TX_MIN |=>
    tx_bcast_pan == $past(opt_reg[OPT_BCAST_PAN]) && tx_len == $past(len_reg) - LEN_TX_MIN;
  endproperty
  a_tx_fields: assert property (p_tx_fields) else $error("transmit fields wrong");

  c_tx:    cover property (@(posedge pclk) tx_req);
  c_cmd:   cover property (@(posedge pclk) rsp_valid && rsp_type == TYPE_LOCAL_RSP);
  c_stat:  cover property (@(posedge pclk) rsp_valid && rsp_type == TYPE_TX_STATUS);
  c_param: cover property (@(posedge pclk) param_we);
  c_bcast: cover property (@(posedge pclk) tx_req && tx_bcast);
endmodule // hafd_frame_decoder

// ### verif/hafd_radio_model.sv
// Behavioural radio that answers the decoder's transmit requests.
// Assumes the decoder's pclk and active-low presetn; ok_in sets the result.
`timescale 1ns/1ns
module hafd_radio_model #(
  parameter int DELAY = 5
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_req,
  input  wire logic ok_in,
  output logic      tx_done,
  output logic      tx_ok
);
  int cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tx_done <= 1'b0;
      tx_ok <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      // The result line carries no meaning outside the done pulse, so it wanders.
      tx_ok <= ~tx_ok;
      if (tx_req) begin
        cnt <= DELAY;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        tx_done <= 1'b1;
        tx_ok <= ok_in;
      end
    end
  end
endmodule // hafd_radio_model

// ### verif/host_api_frame_decoder_test.sv
// Self-checking bench for the API frame decoder: frames in, responses out.
// Assumes the decoder package and the radio model are compiled before it.
`timescale 1ns/1ns
module host_api_frame_decoder_test;
  import hafd_pkg::*;
  typedef struct packed {
    logic [7:0]  t;
    logic [7:0]  id;
    logic [7:0]  st;
    logic [15:0] v;
    logic        vc;
  } hafd_rsp_s;
  typedef struct packed {
    logic [15:0] d;
    logic        b;
    logic        na;
    logic        bp;
    logic [15:0] n;
  } hafd_tx_s;
  logic        pclk, presetn, ce, rx_valid, psel, penable, pwrite, ok_in, esc;
  logic [7:0]  rx_byte, paddr, pay_byte, param_byte, rsp_type, rsp_id, rsp_status;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, tx_done, tx_ok, tx_req, tx_bcast, tx_no_ack, tx_bcast_pan;
  logic        pay_valid, param_we, rsp_valid;
  logic [15:0] tx_dest, tx_len, param_cmd, rsp_value;
  hafd_rsp_s   rq[$];
  hafd_tx_s    tq[$];
  logic [7:0]  pq[$];
  logic [23:0] wq[$];
  int          n_mismatch = 0;
  int          n_compared = 0;

  hafd_frame_decoder #(.MAX_BODY(256)) hafd_frame_decoder_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_done(tx_done), .tx_ok(tx_ok),
    .tx_req(tx_req), .tx_dest(tx_dest), .tx_bcast(tx_bcast), .tx_no_ack(tx_no_ack),
    .tx_bcast_pan(tx_bcast_pan), .tx_len(tx_len), .pay_valid(pay_valid), .pay_byte(pay_byte),
    .param_we(param_we), .param_cmd(param_cmd), .param_byte(param_byte),
    .rsp_valid(rsp_valid), .rsp_type(rsp_type), .rsp_id(rsp_id), .rsp_status(rsp_status),
    .rsp_value(rsp_value));

  hafd_radio_model #(.DELAY(5)) hafd_radio_model_i (
    .pclk(pclk), .presetn(presetn), .tx_req(tx_req), .ok_in(ok_in),
    .tx_done(tx_done), .tx_ok(tx_ok));

  task automatic stop_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // The watcher samples registered pulses at the edge that ends their cycle.
  always @(posedge pclk) begin
    hafd_rsp_s e;
    if (presetn === 1'b1 && rsp_valid === 1'b1) begin
      if (rq.size() == 0) begin
        chk(48'h000000000001, 48'h000000000000);
      end else begin
        e = rq.pop_front();
        chk({8'h00, rsp_type, rsp_id, rsp_status, e.vc ? rsp_value : e.v},
            {8'h00, e.t, e.id, e.st, e.v});
      end
    end
    if (presetn === 1'b1 && tx_req === 1'b1) begin
      if (tq.size() == 0) begin
        chk(48'h000000000001, 48'h000000000000);
      end else begin
        chk({tx_dest, tx_bcast, tx_no_ack, tx_bcast_pan, tx_len}, tq.pop_front());
      end
    end
    if (presetn === 1'b1 && pay_valid === 1'b1) begin
      chk({40'h0, pay_byte}, {40'h0, pq.size() ? pq.pop_front() : 8'h00});
    end
    if (presetn === 1'b1 && param_we === 1'b1) begin
      chk({24'h0, param_cmd, param_byte}, {24'h0, wq.size() ? wq.pop_front() : 24'h0});
    end
  end

  // The byte strobe stays high between bytes of one frame; frame() lowers it.
  task automatic put(input logic [7:0] b);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic putx(input logic [7:0] b);
    if (esc && (b == START_DELIM || b == ESC_BYTE || b == XON_BYTE || b == XOFF_BYTE)) begin
      put(ESC_BYTE);
      put(b ^ ESC_XOR);
    end else begin
      put(b);
    end
  endtask

  task automatic frame(input logic [7:0] body[$], input logic bad);
    logic [7:0] s;
    s = 8'h00;
    put(START_DELIM);
    putx(8'(body.size() >> 8));
    putx(8'(body.size()));
    foreach (body[i]) begin
      putx(body[i]);
      s = s + body[i];
    end
    putx((CSUM_GOOD - s) ^ {7'h00, bad});
    rx_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 300 && (rq.size() + tq.size() + pq.size() + wq.size()) != 0; i++) begin
      @(posedge pclk);
    end
    if (i == 300) begin
      chk(48'h000000000001, 48'h000000000000);
      stop_test();
    end
    // A short grace period lets any unexpected response show.
    repeat (6) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      chk(48'h000000000001, 48'h000000000000);
      stop_test();
    end
    // One idle edge keeps a following call from raising psel in this time step.
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    logic [7:0]  b[$];
    logic [7:0]  id, opt, pb;
    logic [15:0] lf, dst;
    logic [31:0] rd;
    logic        er;
    int          k, j;
    lf = 16'h8DBB;
    {presetn, rx_valid, psel, penable, pwrite, esc} = 6'h00;
    {ce, ok_in} = 2'b11;
    {rx_byte, paddr, pwdata} = 48'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_MAXPAY, 32'h0, rd, er);
    chk({16'h0, rd}, {32'h0, MAXPAY_RESET});
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk({47'h0, er}, 48'h000000000001);
    rq.push_back('{TYPE_LOCAL_RSP, 8'h17, STAT_OK, 16'h0000, 1'b1});
    b = '{TYPE_LOCAL_CMD, 8'h17, 8'h54, 8'h50};
    frame(b, 1'b0);
    drain();
    pq = '{8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
    b = '{TYPE_TX16, 8'h87, 8'h12, 8'h34, 8'h00, 8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
    tq.push_back('{16'h1234, 1'b0, 1'b0, 1'b0, 16'h0006});
    rq.push_back('{TYPE_TX_STATUS, 8'h87, STAT_OK, 16'h0000, 1'b1});
    frame(b, 1'b0);
    drain();
    apb(1'b1, REG_CTRL, 32'h00000001, rd, er);
    esc = 1'b1;
    for (k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      opt = {5'h00, lf[2], 1'b0, lf[0]};
      dst = (k == 3) ? ADDR_BCAST : lf;
      id = (k == 2) ? 8'h00 : {6'h04, k[1:0]};
      ok_in <= k[0];
      b = '{TYPE_TX16, id, dst[15:8], dst[7:0], opt};
      for (j = 0; j <= k; j++) begin
        lf = lfsr(lf);
        b.push_back(lf[7:0]);
        pq.push_back(lf[7:0]);
      end
      tq.push_back('{dst, dst == ADDR_BCAST, opt[0], opt[2], 16'(k + 1)});
      if (id != 8'h00) rq.push_back('{TYPE_TX_STATUS, id, k[0] ? STAT_OK : STAT_ERROR,
                                      16'h0000, 1'b1});
      frame(b, 1'b0);
      drain();
    end
    pb = ESC_BYTE;
    rq.push_back('{TYPE_LOCAL_RSP, XON_BYTE, STAT_OK, 16'h0000, 1'b1});
    wq.push_back({CMD_MAXPAY, pb});
    b = '{TYPE_LOCAL_CMD, XON_BYTE, CMD_MAXPAY[15:8], CMD_MAXPAY[7:0], pb};
    frame(b, 1'b0);
    drain();
    rq.push_back('{TYPE_LOCAL_RSP, XOFF_BYTE, STAT_OK, {8'h00, pb}, 1'b1});
    b = '{TYPE_LOCAL_CMD, XOFF_BYTE, CMD_MAXPAY[15:8], CMD_MAXPAY[7:0]};
    frame(b, 1'b0);
    drain();
    apb(1'b0, REG_MAXPAY, 32'h0, rd, er);
    chk({16'h0, rd}, {40'h0, pb});
    b = '{TYPE_LOCAL_CMD, 8'h22, 8'h54, 8'h50};
    frame(b, 1'b1);
    b = '{8'h09, 8'h23, 8'h54, 8'h50};
    frame(b, 1'b0);
    b = '{TYPE_LOCAL_CMD, 8'h00, 8'h54, 8'h50};
    frame(b, 1'b0);
    rq.push_back('{TYPE_LOCAL_RSP, 8'h24, STAT_OK, 16'h0000, 1'b1});
    b = '{TYPE_LOCAL_CMD, 8'h24, 8'h54, 8'h50};
    frame(b, 1'b0);
    drain();
    stop_test();
  end
endmodule // host_api_frame_decoder_test
